// [core/pin_edge_sync.sv]
// pin_edge_sync: two-flop synchronisers and falling-edge detectors for the
// trigger and count pins; assumes pins are asynchronous to the core clock.
`timescale 1ns/1ns
module pin_edge_sync (
  input wire logic clk_i,          // core clock
  input wire logic rstn_i,         // async reset, active low
  input wire logic trig_pin_i,     // external trigger pin
  input wire logic count_pin_i,    // count input pin
  pin_event_if.src ev              // falling-edge events
);

  logic [1:0] meta;
  logic [1:0] sync;
  logic [1:0] last;

  // meta is read only by sync
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      meta <= 2'h3;
      sync <= 2'h3;
      last <= 2'h3;
    end else begin
      meta <= {count_pin_i, trig_pin_i};
      sync <= meta;
      last <= sync;
    end
  end

  // sampled high then sampled low gives one pulse
  assign ev.trig_fall = last[0] & ~sync[0];   // R14
  assign ev.count_fall = last[1] & ~sync[1];

endmodule : pin_edge_sync

// [core/pin_event_if.sv]
// interface: single-cycle falling-edge events of the two timer pins
// assumes both ends share the core clock.
`timescale 1ns/1ns
interface pin_event_if;
  logic trig_fall;
  logic count_fall;
  modport src (output trig_fall, output count_fall);
  modport dst (input trig_fall, input count_fall);
endinterface : pin_event_if

// [core/reload_capture_timer.sv]
// reload_capture_timer: sixteen-bit timer with autoreload, capture and baud modes
// assumes a single-cycle special function register bus on the core clock.
`timescale 1ns/1ns

// Operation
// [R1] two 8-bit pairs: count low/high and reload/capture low/high
// [R2] mode: run off stops; baud selects win; else capture_select picks reload/capture
// [R3] autoreload: rollover sets overflow_flag and loads count from reload pair
// [R4] autoreload with trigger enable: trigger falling edge reloads, sets external_event_flag
// [R5] capture mode: free 16-bit count, overflow sets overflow_flag, may interrupt
// [R6] capture with trigger enable: trigger falling edge copies count into reload pair
// [R7] trigger capture sets external_event_flag, which interrupts like overflow_flag
// [R8] baud mode never sets overflow_flag
// [R9] baud mode: trigger edge still sets external_event_flag and interrupts
// [R10] baud selects ignore capture_select and force reload on overflow
// [R11] counter_select counts count pin edges, otherwise the core clock
// [R12] hardware only sets the two flags; software clears them by control write
// [R13] overflow pulses go to receive and/or transmit baud outputs per select bits
// [R14] trigger pin synchronised; falling edge is sampled high then low, one pulse
module reload_capture_timer
  import timer2_pkg::*;
(
  input wire logic CORE_CLK_I,          // core clock, 25 MHz
  input wire logic RSTN_I,              // async reset, active low
  input wire logic [7:0] SFR_ADDR_I,    // register address
  input wire logic SFR_WR_I,            // write strobe
  input wire logic [7:0] SFR_WDATA_I,   // write data
  input wire logic SFR_RD_I,            // read strobe
  output logic [7:0] SFR_RDATA_O,       // read data, one cycle after strobe
  output logic SFR_HIT_O,               // read hit this block, with data
  input wire logic TRIG_PIN_I,          // external trigger pin
  input wire logic COUNT_PIN_I,         // external count pin
  output logic RX_BAUD_TICK_O,          // receive baud overflow pulse
  output logic TX_BAUD_TICK_O,          // transmit baud overflow pulse
  output logic TIMER_IRQ_O              // interrupt request level
);

  // ------------------------------------------------------------
  // pin events
  // ------------------------------------------------------------
  pin_event_if ev ();

  pin_edge_sync u_sync (
    .clk_i(CORE_CLK_I),
    .rstn_i(RSTN_I),
    .trig_pin_i(TRIG_PIN_I),
    .count_pin_i(COUNT_PIN_I),
    .ev(ev)
  );

  // ------------------------------------------------------------
  // registers and mode decode
  // ------------------------------------------------------------
  logic [7:0] ctrl;
  logic [7:0] count_low;    // R1
  logic [7:0] count_high;
  logic [7:0] reload_low;
  logic [7:0] reload_high;
  mode_e mode;
  logic baud_sel;
  logic tick;
  logic overflow;
  logic trig;
  logic do_reload;
  logic do_capture;
  logic wr_ctrl;
  logic set_ovf;
  logic set_ext;

  // bus signals passed in: a continuous assignment wakes only on its own operands
  function automatic logic wr_hit(
    input logic wr,
    input logic [7:0] bus_addr,
    input logic [7:0] addr
  );
    wr_hit = wr && (bus_addr == addr);
  endfunction : wr_hit

  assign baud_sel = ctrl[RX_BAUD_BIT] | ctrl[TX_BAUD_BIT];

  always_comb begin
    if (!ctrl[RUN_BIT]) begin
      mode = MODE_OFF;                 // R2
    end else if (baud_sel) begin
      mode = MODE_BAUD;                // R10
    end else if (ctrl[CAP_SEL_BIT]) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // counter input: pin edges or every core clock
  assign tick = (mode != MODE_OFF) && (ctrl[CNT_SEL_BIT] ? ev.count_fall : 1'b1);  // R11
  assign overflow = tick && ({count_high, count_low} == COUNT_MAX);
  // trigger edges count in every mode once enabled, even with the timer stopped
  assign trig = ev.trig_fall && ctrl[EXT_EN_BIT];
  assign do_capture = trig && ctrl[RUN_BIT] && (mode == MODE_CAPTURE);              // R6
  // reload on overflow unless capturing; trigger reload only in autoreload mode
  always_comb begin
    case (mode)
      MODE_RELOAD: do_reload = overflow || trig;                                     // R3 R4
      MODE_BAUD: do_reload = overflow;                                               // R10
      default: do_reload = 1'b0;
    endcase
  end
  assign wr_ctrl = wr_hit(SFR_WR_I, SFR_ADDR_I, CTRL_ADDR);

  // baud mode keeps overflow_flag quiet so the serial clock raises no interrupt
  assign set_ovf = overflow && (mode != MODE_BAUD);                                  // R8
  assign set_ext = trig;                                                             // R9

  // ------------------------------------------------------------
  // control register and flags
  // ------------------------------------------------------------
  // a hardware set in the cycle of a clearing write wins
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      ctrl <= CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl <= SFR_WDATA_I;                                                         // R12
      end
      if (set_ovf) begin
        ctrl[OVF_BIT] <= 1'b1;                                                       // R3 R5 R8
      end
      if (set_ext) begin
        ctrl[EXT_FLAG_BIT] <= 1'b1;                                                  // R4 R7 R9
      end
    end
  end

  assign TIMER_IRQ_O = ctrl[OVF_BIT] | ctrl[EXT_FLAG_BIT];                           // R5 R7 R9

  // ------------------------------------------------------------
  // count pair
  // ------------------------------------------------------------
  // hardware reload wins over a same-cycle software write
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      count_low <= DATA_RESET;
      count_high <= DATA_RESET;
    end else if (do_reload) begin
      count_low <= reload_low;                                                       // R3 R4
      count_high <= reload_high;
    end else begin
      if (tick) begin
        {count_high, count_low} <= {count_high, count_low} + 16'h0001;               // R5
      end
      if (wr_hit(SFR_WR_I, SFR_ADDR_I, COUNT_LOW_ADDR)) begin
        count_low <= SFR_WDATA_I;
      end
      if (wr_hit(SFR_WR_I, SFR_ADDR_I, COUNT_HIGH_ADDR)) begin
        count_high <= SFR_WDATA_I;
      end
    end
  end

  // ------------------------------------------------------------
  // reload/capture pair
  // ------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      reload_low <= DATA_RESET;
      reload_high <= DATA_RESET;
    end else if (do_capture) begin
      reload_low <= count_low;                                                       // R6
      reload_high <= count_high;
    end else begin
      if (wr_hit(SFR_WR_I, SFR_ADDR_I, RELOAD_LOW_ADDR)) begin
        reload_low <= SFR_WDATA_I;
      end
      if (wr_hit(SFR_WR_I, SFR_ADDR_I, RELOAD_HIGH_ADDR)) begin
        reload_high <= SFR_WDATA_I;
      end
    end
  end

  // ------------------------------------------------------------
  // baud ticks
  // ------------------------------------------------------------
  // registered so the serial port sees a clean one-cycle pulse
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      RX_BAUD_TICK_O <= 1'b0;
      TX_BAUD_TICK_O <= 1'b0;
    end else begin
      RX_BAUD_TICK_O <= overflow && ctrl[RUN_BIT] && ctrl[RX_BAUD_BIT];              // R13
      TX_BAUD_TICK_O <= overflow && ctrl[RUN_BIT] && ctrl[TX_BAUD_BIT];              // R13
    end
  end

  // ------------------------------------------------------------
  // read path
  // ------------------------------------------------------------
  // unmapped reads answer 00 with no hit
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      SFR_RDATA_O <= 8'h00;
      SFR_HIT_O <= 1'b0;
    end else begin
      SFR_HIT_O <= 1'b0;
      SFR_RDATA_O <= 8'h00;
      if (SFR_RD_I) begin
        SFR_HIT_O <= 1'b1;
        if (SFR_ADDR_I == CTRL_ADDR) begin
          SFR_RDATA_O <= ctrl;
        end else if (SFR_ADDR_I == RELOAD_LOW_ADDR) begin
          SFR_RDATA_O <= reload_low;
        end else if (SFR_ADDR_I == RELOAD_HIGH_ADDR) begin
          SFR_RDATA_O <= reload_high;
        end else if (SFR_ADDR_I == COUNT_LOW_ADDR) begin
          SFR_RDATA_O <= count_low;
        end else if (SFR_ADDR_I == COUNT_HIGH_ADDR) begin
          SFR_RDATA_O <= count_high;
        end else begin
          SFR_HIT_O <= 1'b0;
        end
      end
    end
  end

endmodule : reload_capture_timer

// [core/timer2_pkg.sv]
// package: register offsets, control bit positions and reset values of the
// sixteen-bit reload/capture timer; assumes an 8-bit special function register bus.
package timer2_pkg;

  // ------------------------------------------------------------
  // register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_ADDR = 8'hc8;
  localparam logic [7:0] RELOAD_LOW_ADDR = 8'hca;
  localparam logic [7:0] RELOAD_HIGH_ADDR = 8'hcb;
  localparam logic [7:0] COUNT_LOW_ADDR = 8'hcc;
  localparam logic [7:0] COUNT_HIGH_ADDR = 8'hcd;

  // ------------------------------------------------------------
  // control register bit positions
  // ------------------------------------------------------------
  localparam int OVF_BIT = 7;
  localparam int EXT_FLAG_BIT = 6;
  localparam int RX_BAUD_BIT = 5;
  localparam int TX_BAUD_BIT = 4;
  localparam int EXT_EN_BIT = 3;
  localparam int RUN_BIT = 2;
  localparam int CNT_SEL_BIT = 1;
  localparam int CAP_SEL_BIT = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] DATA_RESET = 8'h00;
  localparam logic [15:0] COUNT_MAX = 16'hffff;

  typedef enum logic [3:0] {
    MODE_OFF = 4'b0001,
    MODE_RELOAD = 4'b0010,
    MODE_CAPTURE = 4'b0100,
    MODE_BAUD = 4'b1000
  } mode_e;

endpackage : timer2_pkg

// [test/reload_capture_timer_properties.sv]
// checker: bus, baud tick and interrupt properties of the timer
// assumes it is bound to the top module, one clock domain
`timescale 1ns/1ns
module reload_capture_timer_properties
  import timer2_pkg::*;
(
  input wire logic CORE_CLK_I, // clock
  input wire logic RSTN_I, // reset
  input wire logic [7:0] SFR_ADDR_I, // address
  input wire logic SFR_WR_I, // write
  input wire logic [7:0] SFR_WDATA_I, // wdata
  input wire logic SFR_RD_I, // read
  input wire logic [7:0] SFR_RDATA_O, // rdata
  input wire logic SFR_HIT_O, // hit
  input wire logic TRIG_PIN_I, // trigger
  input wire logic RX_BAUD_TICK_O, // rx tick
  input wire logic TX_BAUD_TICK_O, // tx tick
  input wire logic TIMER_IRQ_O // irq
);
  logic [5:0] ctl;
  logic trig_q;
  logic [3:0] trig_age;
  logic ctl_wr, mapped, rx_on, tx_on;
  assign ctl_wr = SFR_WR_I && SFR_ADDR_I == CTRL_ADDR;
  assign mapped = SFR_ADDR_I == CTRL_ADDR || SFR_ADDR_I inside {[8'hca:8'hcd]};
  assign rx_on = ctl[RX_BAUD_BIT] && ctl[RUN_BIT];
  assign tx_on = ctl[TX_BAUD_BIT] && ctl[RUN_BIT];
  // bits 5:0 are never touched by hardware, so a shadow is exact
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I)
      ctl <= 6'h00;
    else if (ctl_wr)
      ctl <= SFR_WDATA_I[5:0];
  end
  // age saturates at f: old edges can no longer reach the flag
  always_ff @(posedge CORE_CLK_I or negedge RSTN_I) begin
    if (!RSTN_I) begin
      trig_q <= 1'b1;
      trig_age <= 4'hf;
    end else begin
      trig_q <= TRIG_PIN_I;
      if (trig_q && !TRIG_PIN_I)
        trig_age <= 4'h0;
      else if (trig_age != 4'hf)
        trig_age <= trig_age + 4'h1;
    end
  end
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (!RSTN_I);
  property p_hit_cause; SFR_HIT_O |-> $past(SFR_RD_I) && $past(mapped); endproperty
  a_hit_cause: assert property (p_hit_cause) else $error("hit without mapped read");
  property p_unmapped; SFR_RD_I && !mapped |=> !SFR_HIT_O && SFR_RDATA_O == 8'h00; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read answered");
  property p_ctl_read; SFR_RD_I && SFR_ADDR_I == CTRL_ADDR |=> SFR_RDATA_O[5:0] == $past(ctl);
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control bits read wrong");
  property p_tick_rx; RX_BAUD_TICK_O |-> $past(rx_on) || $past(rx_on, 2) || $past(rx_on, 3);
  endproperty
  a_tick_rx: assert property (p_tick_rx) else $error("rx tick while not selected");
  property p_tick_tx; TX_BAUD_TICK_O |-> $past(tx_on) || $past(tx_on, 2) || $past(tx_on, 3);
  endproperty
  a_tick_tx: assert property (p_tick_tx) else $error("tx tick while not selected");
  property p_irq_baud; $rose(TIMER_IRQ_O) && ctl[5:4] != 2'b00
    |-> trig_age < 4'h8 || $past(ctl_wr) || $past(ctl_wr, 2); endproperty
  a_irq_baud: assert property (p_irq_baud) else $error("overflow irq in baud mode");
  property p_irq_clear; ctl_wr && SFR_WDATA_I[7:4] == 4'h3 && ctl[5:4] != 2'b00
    && trig_age == 4'hf |=> !TIMER_IRQ_O; endproperty
  a_irq_clear: assert property (p_irq_clear) else $error("flags not cleared");
  property p_ev_irq; trig_q && !TRIG_PIN_I && ctl[EXT_EN_BIT] |-> ##[1:6] TIMER_IRQ_O;
  endproperty
  a_ev_irq: assert property (p_ev_irq) else $error("trigger edge raised no irq");
endmodule : reload_capture_timer_properties
bind reload_capture_timer reload_capture_timer_properties u_props (.*);

// [test/reload_capture_timer_tb.sv]
// testbench: drives the register bus and pins, checks counts, flags and ticks
// assumes the pin model and the bound property checker
`timescale 1ns/1ns
module reload_capture_timer_tb
  import timer2_pkg::*;
;
  logic clk, rstn, wr, rd, trig, cnt, hit, rxt, txt, irq;
  logic [7:0] addr, wdata, rdata, v;
  int n_errors = 0, n_checks = 0, n_rx = 0, n_tx = 0, r0, t0;
  reload_capture_timer uut (.CORE_CLK_I(clk), .RSTN_I(rstn), .SFR_ADDR_I(addr),
    .SFR_WR_I(wr), .SFR_WDATA_I(wdata), .SFR_RD_I(rd), .SFR_RDATA_O(rdata), .SFR_HIT_O(hit),
    .TRIG_PIN_I(trig), .COUNT_PIN_I(cnt), .RX_BAUD_TICK_O(rxt), .TX_BAUD_TICK_O(txt),
    .TIMER_IRQ_O(irq));
  timer_pin_driver pins (.clk_i(clk), .trig_o(trig), .count_o(cnt));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    n_rx += (rxt === 1'b1);
    n_tx += (txt === 1'b1);
  end
  task automatic chk(input string nm, input logic [15:0] s, input logic [15:0] e);
    n_checks++;
    if (s !== e) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    #1;
  endtask : wr_reg
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk(nm, {7'h00, hit, rdata}, {7'h00, h, e});
  endtask : rd_chk
  task automatic load(input logic [7:0] a, input logic [15:0] d);
    wr_reg(a, d[7:0]);
    wr_reg(a + 8'h01, d[15:8]);
  endtask : load
  task automatic t_regs();
    for (int i = 0; i < 4; i++)
      rd_chk("data reset", RELOAD_LOW_ADDR + 8'(i), DATA_RESET, 1'b1);
    rd_chk("ctrl reset", CTRL_ADDR, CTRL_RESET, 1'b1);
    rd_chk("unmapped", 8'hc9, 8'h00, 1'b0);
    load(RELOAD_LOW_ADDR, 16'ha55a);
    rd_chk("reload high", RELOAD_HIGH_ADDR, 8'ha5, 1'b1);
  endtask : t_regs
  task automatic t_reload();
    load(RELOAD_LOW_ADDR, 16'h1234);
    load(COUNT_LOW_ADDR, 16'hfffd);
    wr_reg(CTRL_ADDR, 8'h04);
    repeat (10) @(posedge clk);
    rd_chk("ctrl ovf", CTRL_ADDR, 8'h84, 1'b1);
    wr_reg(CTRL_ADDR, 8'h00);
    chk("irq clear", {15'h0, irq}, 16'h0);
    rd_chk("reloaded", COUNT_HIGH_ADDR, 8'h12, 1'b1);
  endtask : t_reload
  task automatic t_trig_reload();
    load(RELOAD_LOW_ADDR, 16'h4321);
    load(COUNT_LOW_ADDR, 16'h0000);
    wr_reg(CTRL_ADDR, 8'h0c);
    pins.pulse(1'b1, 1);
    rd_chk("ctrl trig", CTRL_ADDR, 8'h4c, 1'b1);
    wr_reg(CTRL_ADDR, 8'h00);
    rd_chk("trig reload", COUNT_HIGH_ADDR, 8'h43, 1'b1);
    rd_chk("stopped", COUNT_LOW_ADDR, 8'h27, 1'b1);
  endtask : t_trig_reload
  task automatic t_capture();
    load(RELOAD_LOW_ADDR, 16'h0000);
    load(COUNT_LOW_ADDR, 16'hfff0);
    wr_reg(CTRL_ADDR, 8'h0d);
    pins.pulse(1'b1, 1);
    repeat (20) @(posedge clk);
    rd_chk("ctrl cap", CTRL_ADDR, 8'hcd, 1'b1);
    rd_chk("captured", RELOAD_HIGH_ADDR, 8'hff, 1'b1);
    rd_chk("wrapped", COUNT_HIGH_ADDR, 8'h00, 1'b1);
    wr_reg(CTRL_ADDR, 8'h00);
  endtask : t_capture
  task automatic t_baud();
    load(RELOAD_LOW_ADDR, 16'hfffc);
    load(COUNT_LOW_ADDR, 16'hfffc);
    wr_reg(CTRL_ADDR, 8'h3d);
    r0 = n_rx;
    t0 = n_tx;
    repeat (40) @(posedge clk);
    chk("rx ticks", 16'(n_rx - r0), 16'h0009);
    chk("tx ticks", 16'(n_tx - t0), 16'h0009);
    chk("no ovf irq", {15'h0, irq}, 16'h0);
    pins.pulse(1'b1, 1);
    #1;
    chk("ext irq", {15'h0, irq}, 16'h1);
    rd_chk("ctrl baud", CTRL_ADDR, 8'h7d, 1'b1);
    repeat (10) @(posedge clk);
    wr_reg(CTRL_ADDR, 8'h35);
    chk("irq cleared", {15'h0, irq}, 16'h0);
    rd_chk("no capture", RELOAD_LOW_ADDR, 8'hfc, 1'b1);
    wr_reg(CTRL_ADDR, 8'h24);
    repeat (4) @(posedge clk);
    #1;
    r0 = n_rx;
    t0 = n_tx;
    repeat (40) @(posedge clk);
    #1;
    chk("tx off", 16'(n_tx - t0), 16'h0);
    chk("rx on", 16'(n_rx - r0), 16'h000a);
    wr_reg(CTRL_ADDR, 8'h00);
  endtask : t_baud
  task automatic t_counter();
    load(COUNT_LOW_ADDR, 16'h0000);
    wr_reg(CTRL_ADDR, 8'h06);
    pins.pulse(1'b0, 5);
    repeat (4) @(posedge clk);
    wr_reg(CTRL_ADDR, 8'h00);
    rd_chk("pin count", COUNT_LOW_ADDR, 8'h05, 1'b1);
  endtask : t_counter
  task automatic end_of_test();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  initial begin
    rstn = 1'b0;
    {wr, rd, addr, wdata} = '0;
    repeat (8) @(posedge clk);
    rstn <= 1'b1;
    t_regs();
    t_reload();
    t_trig_reload();
    t_capture();
    t_baud();
    t_counter();
    end_of_test();
  end
  // the whole sequence needs well under 1000 cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_errors++;
    end_of_test();
  end
endmodule : reload_capture_timer_tb

// [test/timer_pin_driver.sv]
// partner model: drives the trigger and count pins of the timer
// assumes both pins idle high and are stepped on the core clock
`timescale 1ns/1ns
module timer_pin_driver (
  input wire logic clk_i, // core clock
  output logic trig_o, // trigger pin
  output logic count_o // count pin
);
  initial begin
    trig_o = 1'b1;
    count_o = 1'b1;
  end
  // each level held 3 clocks so the two-flop sync never misses it
  task automatic pulse(input logic trig, input int n);
    repeat (n) begin
      @(posedge clk_i);
      if (trig)
        trig_o <= 1'b0;
      else
        count_o <= 1'b0;
      repeat (3) @(posedge clk_i);
      trig_o <= 1'b1;
      count_o <= 1'b1;
      repeat (2) @(posedge clk_i);
    end
  endtask : pulse
endmodule : timer_pin_driver
